// ### verilog/apr_pkg.sv
// Constants, field layout and types shared by the registration latch block
package apr_pkg;
    // ==========================================================
    // Widths and counts
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int POS_W   = 32;
    localparam int NLATCH  = 2;
    localparam int NPIN    = 3;
    localparam int NSRC    = 4;
    localparam int NRAW    = 6;
    localparam int ALLOC_W = 8;

    // ==========================================================
    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ALLOC5 = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_ALLOC6 = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ALLOC7 = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_OPEN   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CLOSE  = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_ARM_A  = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_ARM_B  = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_DONE_A = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_POS_A  = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_DONE_B = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_POS_B  = 8'h2c;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_ENC    = 8'h34;

    // ==========================================================
    // Field positions
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_DRIVE    = 2;
    localparam int ARG_SRC_LSB   = 0;
    localparam int ARG_FALL      = 2;
    localparam int ARG_WIN_LSB   = 3;
    localparam int ARG_W         = 5;
    localparam int ST_ARMED_LSB  = 0;
    localparam int ST_REFUSE_LSB = 2;
    localparam int PIN_IDX       = 3;
    localparam int PIN_A         = 4;
    localparam int PIN_B         = 5;

    // ==========================================================
    // Encodings
    localparam logic [1:0] SRC_IDX  = 2'h3;
    localparam logic [1:0] WIN_OFF  = 2'h0;
    localparam logic [1:0] WIN_INCL = 2'h1;
    localparam logic [1:0] WIN_EXCL = 2'h2;
    localparam logic [ALLOC_W-1:0] ALLOC_CODE [NPIN] = '{8'h20, 8'h21, 8'h28};
    localparam logic [DATA_W-1:0] FLAG_SET = 32'hffffffff;

    typedef enum logic [1:0] {VAR_LOCAL, VAR_SINGLE, VAR_FIXED, VAR_CONFIG} apr_variant_t;

    // ==========================================================
    // Reset values
    localparam logic [1:0]         TYPE_RST  = 2'h0;
    localparam logic [ALLOC_W-1:0] ALLOC_RST = 8'h00;
    localparam logic [POS_W-1:0]   POS_RST   = 32'h00000000;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ          = 250;
    localparam int CAPTURE_DELAY_NS = 500;
    localparam int CAPTURE_CYCLES   = CAPTURE_DELAY_NS * CLK_MHZ / 1000;
    localparam int SERVO_PERIOD_US  = 1000;
    localparam int SERVO_CYCLES_DEF = SERVO_PERIOD_US * CLK_MHZ;
endpackage

// ### verilog/apr_latch_if.sv
// Signals between the register side and one position latch
`timescale 1ns/100ps
interface apr_latch_if;
    import apr_pkg::*;
    logic                    arm;
    logic [ARG_W-1:0]        arg;
    logic [NSRC-1:0]         rise;
    logic [NSRC-1:0]         fall;
    logic signed [POS_W-1:0] pos;
    logic signed [POS_W-1:0] openPos;
    logic signed [POS_W-1:0] closePos;
    logic                    armed;
    logic                    done;
    logic signed [POS_W-1:0] capPos;
    modport unit (input arm, arg, rise, fall, pos, openPos, closePos,
                  output armed, done, capPos);
    modport ctrl (output arm, arg, rise, fall, pos, openPos, closePos,
                  input armed, done, capPos);
endinterface

// ### verilog/apr_latch_unit.sv
// One position latch: arm, edge capture, window test and automatic re-arm
`timescale 1ns/100ps
module apr_latch_unit (
    input  logic          clk,
    input  logic          sys_rst,
    apr_latch_if.unit     lat
);
    import apr_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_DONE} apr_lstate_t;

    apr_lstate_t             state;
    apr_lstate_t             next_state;
    logic [ARG_W-1:0]        arg;
    logic [ARG_W-1:0]        next_arg;
    logic signed [POS_W-1:0] capPos;
    logic signed [POS_W-1:0] next_capPos;
    logic                    trig;
    logic                    pass;

    function automatic logic winPass(input logic [1:0] mode,
                                     input logic signed [POS_W-1:0] p, o, c);
        case (mode)
            WIN_INCL: winPass = !(p < o || p > c);
            WIN_EXCL: winPass = !(p > o || p < c);
            default:  winPass = 1'b1;
        endcase
    endfunction

    // ==========================================================
    // Latch sequence
    always_comb begin
        trig = arg[ARG_FALL] ? lat.fall[arg[ARG_SRC_LSB +: 2]]
                             : lat.rise[arg[ARG_SRC_LSB +: 2]];
        pass = winPass(arg[ARG_WIN_LSB +: 2], lat.pos, lat.openPos, lat.closePos);
        next_state  = state;
        next_arg    = arg;
        next_capPos = capPos;
        if (lat.arm) begin
            next_state = ST_ARMED;
            next_arg   = lat.arg;
        end else begin
            case (state)
                ST_ARMED: begin
                    // Failed window test simply stays armed
                    if (trig && pass) begin
                        next_state  = ST_DONE;
                        next_capPos = lat.pos;
                    end
                end
                default: ; // Done holds until re-armed
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state  <= ST_IDLE;
            arg    <= '0;
            capPos <= POS_RST;
        end else begin
            state  <= next_state;
            arg    <= next_arg;
            capPos <= next_capPos;
        end
    end

    assign lat.armed  = (state == ST_ARMED);
    assign lat.done   = (state == ST_DONE);
    assign lat.capPos = capPos;

    // ==========================================================
    // Checks
    property p_arm_clears;
        @(posedge clk) disable iff (sys_rst) lat.arm |=> lat.armed && !lat.done;
    endproperty
    a_arm_clears: assert property (p_arm_clears) else $error("arm did not clear done");

    property p_capture;
        @(posedge clk) disable iff (sys_rst)
        lat.armed && !lat.arm && trig && pass |=> lat.done && capPos == $past(lat.pos);
    endproperty
    a_capture: assert property (p_capture) else $error("passing edge not captured");

    property p_rearm;
        @(posedge clk) disable iff (sys_rst)
        lat.armed && !lat.arm && trig && !pass |=> lat.armed && $stable(capPos);
    endproperty
    a_rearm: assert property (p_rearm) else $error("failed window did not re-arm");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        lat.done && !lat.arm |=> lat.done && $stable(capPos);
    endproperty
    a_hold: assert property (p_hold) else $error("captured value not held");

    property p_incl;
        @(posedge clk) disable iff (sys_rst)
        lat.armed && !lat.arm && arg[ARG_WIN_LSB +: 2] == WIN_INCL
            && lat.pos < lat.openPos |=> !lat.done;
    endproperty
    a_incl: assert property (p_incl) else $error("inclusive window accepted low");

    property p_excl;
        @(posedge clk) disable iff (sys_rst)
        lat.armed && !lat.arm && arg[ARG_WIN_LSB +: 2] == WIN_EXCL
            && lat.pos > lat.openPos |=> !lat.done;
    endproperty
    a_excl: assert property (p_excl) else $error("exclusive window accepted high");
endmodule

// ### verilog/apr_registration.sv
// Axis position registration: pin sync, encoder count, APB registers, two latches
//
// Operation
// - Single variant: one input, logical 1, rising
// - Fixed variant: three inputs fixed, one, rising
// - Some variants arm only with drive enabled
// - Configurable variant: three inputs, two latches
// - Local sources: two inputs plus index
// - Two independent latches, own flag, position
// - Capture within 0.5 us of edge
// - Capture samples live encoder counter
// - Result visible within one servo cycle
// - Done flag reads -1 captured, 0 not
// - Arming clears done and enables latch
// - Optional window selected by arming argument
// - Inclusive: drop below open, above close
// - Exclusive: drop above open, below close
// - Pass sets done, updates position
// - Fail re-arms latch, done stays 0
`timescale 1ns/100ps
module apr_registration #(
    parameter int SERVO_CYCLES = apr_pkg::SERVO_CYCLES_DEF
) (
    input  logic                       clk,
    input  logic                       sys_rst,
    input  logic                       psel,
    input  logic                       penable,
    input  logic                       pwrite,
    input  logic [apr_pkg::ADDR_W-1:0] paddr,
    input  logic [apr_pkg::DATA_W-1:0] pwdata,
    output logic [apr_pkg::DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  logic [apr_pkg::NPIN-1:0]   extIn,
    input  logic                       encIndex,
    input  logic                       encA,
    input  logic                       encB
);
    import apr_pkg::*;

    localparam int CAP_LIMIT = CAPTURE_CYCLES;

    // ==========================================================
    // Pin synchronisers, edges, encoder counter, servo tick
    logic [NRAW-1:0]         syncA;
    logic [NRAW-1:0]         syncB;
    logic [NRAW-1:0]         pinPrev;
    logic [NSRC-1:0]         srcNow;
    logic [NSRC-1:0]         srcPrev;
    logic signed [POS_W-1:0] encPos;
    logic signed [POS_W-1:0] next_encPos;
    logic [31:0]             servoCnt;
    logic [31:0]             next_servoCnt;
    logic                    servoTick;
    logic                    next_servoTick;

    // ==========================================================
    // Register state
    apr_variant_t            variant;
    apr_variant_t            next_variant;
    logic                    driveEnable;
    logic                    next_driveEnable;
    logic [ALLOC_W-1:0]      alloc [NPIN];
    logic [ALLOC_W-1:0]      next_alloc [NPIN];
    logic signed [POS_W-1:0] openPos;
    logic signed [POS_W-1:0] next_openPos;
    logic signed [POS_W-1:0] closePos;
    logic signed [POS_W-1:0] next_closePos;
    logic [ARG_W-1:0]        armArg [NLATCH];
    logic [ARG_W-1:0]        next_armArg [NLATCH];
    logic [NLATCH-1:0]       armPulse;
    logic [NLATCH-1:0]       next_armPulse;
    logic [NLATCH-1:0]       refused;
    logic [NLATCH-1:0]       next_refused;
    logic [NLATCH-1:0]       repDone;
    logic [NLATCH-1:0]       next_repDone;
    logic [POS_W-1:0]        repPos [NLATCH];
    logic [POS_W-1:0]        next_repPos [NLATCH];
    logic [DATA_W-1:0]       next_prdata;
    logic                    next_pready;
    logic                    next_pslverr;
    logic                    wrEn;
    logic [NLATCH-1:0]       latDone;
    logic [NLATCH-1:0]       latArmed;
    logic [POS_W-1:0]        latPos [NLATCH];

    apr_latch_if lif [NLATCH] ();

    // Second latch exists only where the drive has two; some variants need drive on
    function automatic logic armAllowed(input apr_variant_t v, input logic drv,
                                        input int idx);
        logic twoLatch;
        logic gated;
        twoLatch = (v == VAR_LOCAL) || (v == VAR_CONFIG);
        gated    = (v == VAR_FIXED) || (v == VAR_CONFIG);
        armAllowed = (idx == 0 || twoLatch) && (!gated || drv);
    endfunction

    always_comb begin
        srcNow = '0;
        case (variant)
            VAR_SINGLE: srcNow[0] = syncB[0];
            VAR_FIXED:  srcNow[NPIN-1:0] = syncB[NPIN-1:0];
            VAR_CONFIG: begin
                for (int k = 0; k < NPIN; k++) begin
                    for (int j = 0; j < NPIN; j++) begin
                        if (alloc[j] == ALLOC_CODE[k] && syncB[j]) begin
                            srcNow[k] = 1'b1;
                        end
                    end
                end
            end
            default: srcNow[1:0] = syncB[1:0];
        endcase
        srcNow[SRC_IDX] = syncB[PIN_IDX];
        next_encPos = encPos;
        if ((syncB[PIN_A] ^ pinPrev[PIN_A]) || (syncB[PIN_B] ^ pinPrev[PIN_B])) begin
            // Direction from the newest A against the previous B
            if (syncB[PIN_A] ^ pinPrev[PIN_B]) begin
                next_encPos = encPos + 32'sh1;
            end else begin
                next_encPos = encPos - 32'sh1;
            end
        end
        next_servoTick = (servoCnt == 32'(SERVO_CYCLES - 1));
        next_servoCnt  = next_servoTick ? 32'h0 : servoCnt + 32'h1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncA     <= '0;
            syncB     <= '0;
            pinPrev   <= '0;
            srcPrev   <= '0;
            encPos    <= POS_RST;
            servoCnt  <= 32'h0;
            servoTick <= 1'b0;
        end else begin
            syncA     <= {encB, encA, encIndex, extIn};
            syncB     <= syncA;
            pinPrev   <= syncB;
            srcPrev   <= srcNow;
            encPos    <= next_encPos;
            servoCnt  <= next_servoCnt;
            servoTick <= next_servoTick;
        end
    end

    // ==========================================================
    // Latch instances
    for (genvar g = 0; g < NLATCH; g++) begin : g_latch
        assign lif[g].arm      = armPulse[g];
        assign lif[g].arg      = armArg[g];
        assign lif[g].rise     = srcNow & ~srcPrev;
        assign lif[g].fall     = ~srcNow & srcPrev;
        assign lif[g].pos      = encPos;
        assign lif[g].openPos  = openPos;
        assign lif[g].closePos = closePos;
        assign latDone[g]      = lif[g].done;
        assign latArmed[g]     = lif[g].armed;
        assign latPos[g]       = lif[g].capPos;
        apr_latch_unit u_latch (
            .clk     (clk),
            .sys_rst (sys_rst),
            .lat     (lif[g])
        );
    end

    // ==========================================================
    // APB slave: no wait states, answer registered in setup
    assign wrEn = psel && penable && pwrite && pready;

    always_comb begin
        next_variant     = variant;
        next_driveEnable = driveEnable;
        next_alloc       = alloc;
        next_openPos     = openPos;
        next_closePos    = closePos;
        next_armArg      = armArg;
        next_armPulse    = '0;
        next_refused     = refused;
        next_repDone     = repDone;
        next_repPos      = repPos;
        next_pready      = psel && !penable;
        next_pslverr     = 1'b0;
        next_prdata      = '0;
        for (int g = 0; g < NLATCH; g++) begin
            // Done of an arm in flight is stale; report only settled state
            if (servoTick && !armPulse[g]) begin
                next_repDone[g] = latDone[g];
                if (latDone[g]) begin
                    next_repPos[g] = latPos[g];
                end
            end
        end
        if (wrEn) begin
            case (paddr)
                ADDR_CTRL: begin
                    next_variant     = apr_variant_t'(pwdata[CTRL_TYPE_LSB +: 2]);
                    next_driveEnable = pwdata[CTRL_DRIVE];
                end
                ADDR_ALLOC5: next_alloc[0] = pwdata[ALLOC_W-1:0];
                ADDR_ALLOC6: next_alloc[1] = pwdata[ALLOC_W-1:0];
                ADDR_ALLOC7: next_alloc[2] = pwdata[ALLOC_W-1:0];
                ADDR_OPEN:   next_openPos  = pwdata;
                ADDR_CLOSE:  next_closePos = pwdata;
                ADDR_ARM_A, ADDR_ARM_B: begin
                    for (int g = 0; g < NLATCH; g++) begin
                        if (paddr == (g == 0 ? ADDR_ARM_A : ADDR_ARM_B)) begin
                            if (armAllowed(variant, driveEnable, g)) begin
                                next_armPulse[g] = 1'b1;
                                next_repDone[g]  = 1'b0;
                                next_armArg[g]   = pwdata[ARG_W-1:0];
                                // Only the local interface offers falling edges
                                if (variant != VAR_LOCAL) begin
                                    next_armArg[g][ARG_FALL] = 1'b0;
                                end
                            end else begin
                                next_refused[g] = 1'b1;
                            end
                        end
                    end
                end
                ADDR_STATUS: begin
                    // Write one clears; the clear acts on the registered refused bits
                    for (int g = 0; g < NLATCH; g++) begin
                        if (pwdata[ST_REFUSE_LSB + g] && !next_refused[g]) begin
                            next_refused[g] = 1'b0;
                        end
                    end
                    next_refused = refused & ~pwdata[ST_REFUSE_LSB +: NLATCH];
                end
                default: ;
            endcase
        end
        if (psel && !penable) begin
            case (paddr)
                ADDR_CTRL:   next_prdata = DATA_W'({driveEnable, 2'(variant)});
                ADDR_ALLOC5: next_prdata = DATA_W'(alloc[0]);
                ADDR_ALLOC6: next_prdata = DATA_W'(alloc[1]);
                ADDR_ALLOC7: next_prdata = DATA_W'(alloc[2]);
                ADDR_OPEN:   next_prdata = openPos;
                ADDR_CLOSE:  next_prdata = closePos;
                ADDR_ARM_A:  next_prdata = DATA_W'(armArg[0]);
                ADDR_ARM_B:  next_prdata = DATA_W'(armArg[1]);
                ADDR_DONE_A: next_prdata = repDone[0] ? FLAG_SET : '0;
                ADDR_POS_A:  next_prdata = repPos[0];
                ADDR_DONE_B: next_prdata = repDone[1] ? FLAG_SET : '0;
                ADDR_POS_B:  next_prdata = repPos[1];
                ADDR_STATUS: next_prdata = DATA_W'({refused, latArmed});
                ADDR_ENC:    next_prdata = encPos;
                default:     next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            variant     <= apr_variant_t'(TYPE_RST);
            driveEnable <= 1'b0;
            alloc       <= '{default: ALLOC_RST};
            openPos     <= POS_RST;
            closePos    <= POS_RST;
            armArg      <= '{default: '0};
            armPulse    <= '0;
            refused     <= '0;
            repDone     <= '0;
            repPos      <= '{default: POS_RST};
            prdata      <= '0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            variant     <= next_variant;
            driveEnable <= next_driveEnable;
            alloc       <= next_alloc;
            openPos     <= next_openPos;
            closePos    <= next_closePos;
            armArg      <= next_armArg;
            armPulse    <= next_armPulse;
            refused     <= next_refused;
            repDone     <= next_repDone;
            repPos      <= next_repPos;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
        end
    end

    // ==========================================================
    // Checks
    property p_arm_gate;
        @(posedge clk) disable iff (sys_rst)
        wrEn && paddr == ADDR_ARM_A && variant == VAR_FIXED && !driveEnable
            |=> !armPulse[0] && refused[0];
    endproperty
    a_arm_gate: assert property (p_arm_gate) else $error("arm taken with drive off");

    property p_capture_delay;
        @(posedge clk) disable iff (sys_rst)
        latArmed[0] && !armPulse[0] && armArg[0] == ARG_W'(SRC_IDX) && $rose(encIndex)
            |-> ##[1:CAP_LIMIT] (latDone[0] || armPulse[0]);
    endproperty
    a_capture_delay: assert property (p_capture_delay) else $error("capture too late");

    property p_report;
        @(posedge clk) disable iff (sys_rst)
        servoTick && latDone[1] && !armPulse[1] && !(wrEn && paddr == ADDR_ARM_B)
            |=> repDone[1] && repPos[1] == $past(latPos[1]);
    endproperty
    a_report: assert property (p_report) else $error("result not reported on tick");

    property p_rising_only;
        @(posedge clk) disable iff (sys_rst)
        armPulse[0] && variant != VAR_LOCAL |-> !armArg[0][ARG_FALL];
    endproperty
    a_rising_only: assert property (p_rising_only) else $error("falling edge allowed");
endmodule

// ### test/apr_sensor_model.sv
// Behavioural registration sensors and quadrature encoder
`timescale 1ns/100ps
module apr_sensor_model (
    input  logic       clk,
    output logic [2:0] extIn,
    output logic       encIndex,
    output logic       encA,
    output logic       encB
);
    logic [1:0] phase;
    // ==========================================
    // Encoder: Gray order 00,10,11,01 means A leads B, forward count
    assign encA = phase[0] ^ phase[1];
    assign encB = phase[1];
    initial begin
        extIn = '0;
        encIndex = 1'b0;
        phase = 2'h0;
    end
    // ==========================================
    // Pulses wide enough for the two-flop synchroniser; index is source 3
    // Optional travel of n steps while the input is held, so both edges differ
    task automatic pulseMove(input int i, input int n);
        @(posedge clk);
        if (i == 3) encIndex <= 1'b1;
        else extIn <= 3'h1 << i;
        repeat (8) @(posedge clk);
        if (n > 0) step(n);
        extIn <= '0;
        encIndex <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic pulse(input int i);
        pulseMove(i, 0);
    endtask
    // Settle time lets the count pass the synchroniser before anyone reads it
    task automatic step(input int n);
        repeat (n * 4) begin
            repeat (4) @(posedge clk);
            phase <= phase + 2'h1;
        end
        repeat (4) @(posedge clk);
    endtask
endmodule

// ### test/test_apr_registration.sv
// Self-checking bench for the registration latch block
`timescale 1ns/100ps
module test_apr_registration;
    import apr_pkg::*;
    localparam int SC = 64;
    logic              clk = 1'b0;
    logic              sysRst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata, rd, enc, cap;
    logic              pready, pslverr, err, encIndex, encA, encB;
    logic [NPIN-1:0]   extIn;
    int                err_count = 0;
    int                num_checks = 0;
    always #2 clk = ~clk;
    apr_registration #(.SERVO_CYCLES(SC)) uut (.clk(clk), .sys_rst(sysRst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extIn(extIn), .encIndex(encIndex),
        .encA(encA), .encB(encB));
    apr_sensor_model pm (.clk(clk), .extIn(extIn), .encIndex(encIndex), .encA(encA),
        .encB(encB));
    // ==========================================
    // Access and compare helpers
    task automatic final_report();
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk("pready", pready, 1'b1);
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, '0);
        chk(nm, rd, e);
    endtask
    task automatic arm(input logic [ADDR_W-1:0] a, input logic [1:0] win, src);
        apb(1'b1, a, {27'h0, win, 1'b0, src});
    endtask
    task automatic readEnc();
        apb(1'b0, ADDR_ENC, '0);
        enc = rd;
    endtask
    // Latency bound: a few servo periods of polling
    task automatic waitFlag(input logic [ADDR_W-1:0] a);
        int i;
        i = 0;
        do begin
            apb(1'b0, a, '0);
            i++;
        end while (rd !== FLAG_SET && i < 60);
        chk("done", rd, FLAG_SET);
        if (rd !== FLAG_SET) final_report();
    endtask
    // ==========================================
    // Scenarios
    initial begin
        sysRst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= '0;
        pwdata <= '0;
        repeat (10) @(posedge clk);
        sysRst <= 1'b0;
        rdc("doneA rst", ADDR_DONE_A, '0);
        pm.step(5);
        readEnc();
        arm(ADDR_ARM_A, WIN_OFF, 2'h0);
        rdc("doneA arm", ADDR_DONE_A, '0);
        pm.pulse(0);
        pm.step(3);
        pm.pulse(0);
        waitFlag(ADDR_DONE_A);
        rdc("posA", ADDR_POS_A, enc);
        cap = enc;
        for (int k = 0; k < 2; k++) begin
            readEnc();
            apb(1'b1, ADDR_OPEN, k ? enc - 100 : enc + 100);
            apb(1'b1, ADDR_CLOSE, k ? enc + 100 : enc + 200);
            arm(ADDR_ARM_A, k ? WIN_EXCL : WIN_INCL, 2'h0);
            pm.pulse(0);
            repeat (2 * SC) @(posedge clk);
            rdc("doneA win", ADDR_DONE_A, '0);
            rdc("posA keep", ADDR_POS_A, cap);
            apb(1'b0, ADDR_STATUS, '0);
            chk("armedA", rd[0], 1'b1);
            // Margins of 100 counts absorb the re-arm delay
            apb(1'b1, ADDR_OPEN, k ? enc + 100 : enc - 100);
            apb(1'b1, ADDR_CLOSE, k ? enc - 100 : enc + 100);
            pm.pulse(0);
            waitFlag(ADDR_DONE_A);
            rdc("posA win", ADDR_POS_A, enc);
            cap = enc;
        end
        arm(ADDR_ARM_A, WIN_OFF, SRC_IDX);
        arm(ADDR_ARM_B, WIN_OFF, 2'h1);
        readEnc();
        pm.pulse(1);
        cap = enc;
        pm.step(4);
        readEnc();
        pm.pulse(3);
        waitFlag(ADDR_DONE_B);
        rdc("posB", ADDR_POS_B, cap);
        waitFlag(ADDR_DONE_A);
        rdc("posA idx", ADDR_POS_A, enc);
        // Falling edge arrives 8 counts after the rising one
        readEnc();
        apb(1'b1, ADDR_ARM_B, 32'h5);
        rdc("argB", ADDR_ARM_B, 32'h5);
        pm.pulseMove(1, 2);
        waitFlag(ADDR_DONE_B);
        rdc("posB fall", ADDR_POS_B, enc + 32'h8);
        for (int v = 1; v < 4; v++) begin
            apb(1'b1, ADDR_CTRL, v);
            apb(1'b1, ADDR_STATUS, 32'hc);
            arm(ADDR_ARM_B, WIN_OFF, 2'h1);
            apb(1'b1, ADDR_ARM_A, 32'h5);
            apb(1'b0, ADDR_STATUS, '0);
            chk("refusedB", rd[3], 1'b1);
            chk("refusedA", rd[2], v != 1);
        end
        rdc("argA", ADDR_ARM_A, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h7);
        apb(1'b1, ADDR_ALLOC5, 32'h21);
        arm(ADDR_ARM_B, WIN_OFF, 2'h1);
        rdc("doneB arm", ADDR_DONE_B, '0);
        pm.pulse(0);
        waitFlag(ADDR_DONE_B);
        apb(1'b0, 8'h3c, '0);
        chk("pslverr", err, 1'b1);
        chk("rd bad", rd, '0);
        final_report();
    end
endmodule
